// [rtl/scr_pkg.sv]
// Package of constants for the security configuration register bank
// Behaviour
// [RULE1] Fetch block bit 9 set stops secure fetches from non-secure memory; resets clear.
// [RULE2] Hyp call enable bit 8 resets 0; while 0 hyp call undefined in non-secure kernel.
// [RULE3] Monitor call disable bit 7 resets 0; when 1 monitor call undefined non-secure.
// [RULE4] Bit 6 has no function; reads unknown (zero here); software writes zero.
// [RULE5] Abort mask writable bit 5 resets 0; when 0 abort mask changes only secure.
// [RULE6] Fast irq mask writable bit 4 resets 0; when 0 mask changes only secure.
// [RULE7] Bit 3 routes external aborts: 0 abort mode, 1 monitor mode.
// [RULE8] Bit 2 routes fast interrupts: 0 fast-interrupt mode, 1 monitor mode.
// [RULE9] Bit 1 routes normal interrupts: 0 IRQ mode, 1 monitor mode.
// [RULE10] Outside monitor mode bit 0 sets world: 0 secure, 1 non-secure.
// [RULE11] Monitor mode always counts as secure regardless of world select.
// [RULE12] In monitor mode world select picks the banked system register copy.
// [RULE13] Software reaches config register via coprocessor 15, op1 0, c1, c1, op2 0.
// [RULE14] Permit register writable in secure kernel, read-only in non-secure kernel or hyp; here hyp may also write while world bit 0 is 0.
// [RULE15] Bit 18 resets 0; when 1 non-secure aux writes change only coherency bit.
// [RULE16] Bit 17 resets 0; when 1 non-secure l2 writes change only bus error bit.
// [RULE17] Config register accessible only from secure kernel privilege modes; here hyp may also access it while world bit 0 is 0.
// [RULE18] Access without the required right raises an undefined-instruction exception.
package scr_pkg;
   localparam logic [3:0] CP_NUM = 4'hf;
   localparam logic [2:0] CFG_OP1 = 3'h0;
   localparam logic [3:0] CFG_CRN = 4'h1;
   localparam logic [3:0] CFG_CRM = 4'h1;
   localparam logic [2:0] CFG_OP2 = 3'h0;
   localparam logic [2:0] PRM_OP2 = 3'h2;
   localparam int B_FETCH = 9;
   localparam int B_HCE = 8;
   localparam int B_SCD = 7;
   localparam int B_AW = 5;
   localparam int B_FW = 4;
   localparam int B_EA = 3;
   localparam int B_FIQ = 2;
   localparam int B_IRQ = 1;
   localparam int B_WORLD = 0;
   localparam int B_COH = 18;
   localparam int B_L2E = 17;
   localparam logic [31:0] CFG_MASK = 32'h0000_03bf;
   localparam logic [31:0] PRM_MASK = 32'h0006_0000;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] PRM_RESET = 32'h0000_0000;
   localparam int AUX_COH_BIT = 6;
   localparam int L2_ERR_BIT = 29;
   // Processor mode encodings seen on the mode input
   localparam logic [4:0] MODE_USR = 5'h10;
   localparam logic [4:0] MODE_MON = 5'h16;
   localparam logic [4:0] MODE_HYP = 5'h1a;
endpackage

// [rtl/scr_acc_if.sv]
// Access request and verdict signals between decode and register bank
`timescale 1ns/1ps
interface scr_acc_if;
   logic hit_cfg;
   logic hit_prm;
   logic allow_rd;
   logic allow_wr;
   logic denied;
   modport dec (output hit_cfg, hit_prm, allow_rd, allow_wr, denied);
   modport bank (input hit_cfg, hit_prm, allow_rd, allow_wr, denied);
endinterface

// [rtl/scr_decode.sv]
// Instruction decode and privilege check for the two registers
`timescale 1ns/1ps
module scr_decode
   import scr_pkg::*;
(
   input wire logic req, // Transfer valid
   input wire logic is_rd, // Read when high
   input wire logic [3:0] cp, // Coprocessor number
   input wire logic [2:0] op1, // Opcode1
   input wire logic [3:0] crn, // Primary register
   input wire logic [3:0] crm, // Secondary register
   input wire logic [2:0] op2, // Opcode2
   input wire logic [4:0] mode, // Current mode
   input wire logic nonsec, // Effective world, high for non-secure
   scr_acc_if.dec acc // Verdict
);
   logic base;
   logic kern;
   logic perm;
   always_comb begin
      base = req && cp == CP_NUM && op1 == CFG_OP1 && crn == CFG_CRN && crm == CFG_CRM;
      kern = mode != MODE_USR;
      acc.hit_cfg = base && op2 == CFG_OP2; // RULE13
      acc.hit_prm = base && op2 == PRM_OP2;
      perm = 1'b0;
      if (acc.hit_cfg) begin
         perm = kern && !nonsec; // RULE17
      end else if (acc.hit_prm) begin
         perm = kern && (!nonsec || is_rd); // RULE14
      end
      acc.allow_rd = perm && is_rd;
      acc.allow_wr = perm && !is_rd;
      acc.denied = (acc.hit_cfg || acc.hit_prm) && !perm; // RULE18
   end
endmodule

// [rtl/scr_top.sv]
// Security configuration and non-secure permit register bank
`timescale 1ns/1ps
module scr_top
   import scr_pkg::*;
(
   input wire logic ref_clk, // Core clock
   input wire logic rst, // Sync reset, high
   input wire logic clk_en, // Freezes state when low
   input wire logic req, // Coprocessor transfer valid
   input wire logic is_rd, // Read when high
   input wire logic [3:0] cp, // Coprocessor number
   input wire logic [2:0] op1, // Opcode1
   input wire logic [3:0] crn, // Primary register
   input wire logic [3:0] crm, // Secondary register
   input wire logic [2:0] op2, // Opcode2
   input wire logic [31:0] wdata, // Write data
   input wire logic [4:0] mode, // Current processor mode
   input wire logic hyp_call, // Hyp call decoded
   input wire logic mon_call, // Monitor call decoded
   input wire logic abt_wr, // Request to change abort mask
   input wire logic fiq_wr, // Request to change fast irq mask
   input wire logic aux_wr, // Write to aux control
   input wire logic l2_wr, // Write to l2 extended control
   output logic [31:0] rdata, // Read data
   output logic rd_valid, // Read data valid pulse
   output logic undef_exc, // Undefined-instruction pulse
   output logic nonsec_world, // Effective world, high non-secure
   output logic bank_nonsec, // Banked register copy select
   output logic fetch_block, // Secure fetch from ns memory blocked
   output logic irq_to_mon, // Normal interrupts to monitor
   output logic fiq_to_mon, // Fast interrupts to monitor
   output logic ea_to_mon, // External aborts to monitor
   output logic abt_wr_ok, // Abort mask change allowed
   output logic fiq_wr_ok, // Fast irq mask change allowed
   output logic [31:0] aux_wr_mask, // Writable aux control bits
   output logic [31:0] l2_wr_mask // Writable l2 control bits
);
   ////////////////////////////////////////////////////////////
   logic [31:0] cfg_reg, cfg_next;
   logic [31:0] prm_reg, prm_next;
   logic [31:0] rdata_reg, rdata_next;
   logic rdv_reg, rdv_next;
   logic und_reg, und_next;
   logic ns_reg, ns_next;
   logic bank_reg, bank_next;
   logic fb_reg, fb_next;
   logic irq_reg, irq_next;
   logic fiq_reg, fiq_next;
   logic ea_reg, ea_next;
   logic aw_reg, aw_next;
   logic fw_reg, fw_next;
   logic [31:0] auxm_reg, auxm_next;
   logic [31:0] l2m_reg, l2m_next;
   logic in_mon;
   logic ns_eff;
   logic kern;
   scr_acc_if acc ();

   ////////////////////////////////////////////////////////////
   // Decode uses live world so a change takes effect next access
   scr_decode u_dec (
      .req(req),
      .is_rd(is_rd),
      .cp(cp),
      .op1(op1),
      .crn(crn),
      .crm(crm),
      .op2(op2),
      .mode(mode),
      .nonsec(ns_eff),
      .acc(acc)
   );

   ////////////////////////////////////////////////////////////
   // World kept apart so decode and register update form no process loop
   always_comb begin
      in_mon = mode == MODE_MON;
      kern = mode != MODE_USR;
      ns_eff = cfg_reg[B_WORLD] && !in_mon; // RULE10 RULE11
   end

   ////////////////////////////////////////////////////////////
   always_comb begin
      cfg_next = cfg_reg;
      prm_next = prm_reg;
      rdata_next = 32'h0000_0000;
      rdv_next = 1'b0;
      und_next = acc.denied;
      if (acc.hit_cfg && acc.allow_wr) begin
         // Bit 6 and reserved bits never store
         cfg_next = wdata & CFG_MASK; // RULE4
      end
      if (acc.hit_prm && acc.allow_wr) begin
         prm_next = wdata & PRM_MASK; // RULE14
      end
      if (acc.allow_rd) begin
         rdv_next = 1'b1;
         rdata_next = acc.hit_cfg ? (cfg_reg & CFG_MASK) : (prm_reg & PRM_MASK);
      end
      if (hyp_call && ns_eff && kern && mode != MODE_HYP && !cfg_reg[B_HCE]) begin
         und_next = 1'b1; // RULE2
      end
      if (mon_call && ns_eff && cfg_reg[B_SCD]) begin
         und_next = 1'b1; // RULE3
      end
   end

   ////////////////////////////////////////////////////////////
   always_comb begin
      ns_next = ns_eff;
      bank_next = cfg_reg[B_WORLD]; // RULE12
      fb_next = cfg_reg[B_FETCH] && !ns_eff; // RULE1
      irq_next = cfg_reg[B_IRQ]; // RULE9
      fiq_next = cfg_reg[B_FIQ]; // RULE8
      ea_next = cfg_reg[B_EA]; // RULE7
      aw_next = abt_wr && (!ns_eff || cfg_reg[B_AW]); // RULE5
      fw_next = fiq_wr && (!ns_eff || cfg_reg[B_FW]); // RULE6
      auxm_next = 32'h0000_0000;
      l2m_next = 32'h0000_0000;
      if (aux_wr) begin
         if (!ns_eff) begin
            auxm_next = 32'hffff_ffff;
         end else if (prm_reg[B_COH]) begin
            auxm_next[AUX_COH_BIT] = 1'b1; // RULE15
         end
      end
      if (l2_wr) begin
         if (!ns_eff) begin
            l2m_next = 32'hffff_ffff;
         end else if (prm_reg[B_L2E]) begin
            l2m_next[L2_ERR_BIT] = 1'b1; // RULE16
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Register and answer group
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_reg <= CFG_RESET;
         prm_reg <= PRM_RESET;
         rdata_reg <= 32'h0000_0000;
         rdv_reg <= 1'b0;
         und_reg <= 1'b0;
      end else if (clk_en) begin
         cfg_reg <= cfg_next;
         prm_reg <= prm_next;
         rdata_reg <= rdata_next;
         rdv_reg <= rdv_next;
         und_reg <= und_next;
      end
   end

   ////////////////////////////////////////////////////////////
   // Status and permission group
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ns_reg <= 1'b0;
         bank_reg <= 1'b0;
         fb_reg <= 1'b0;
         irq_reg <= 1'b0;
         fiq_reg <= 1'b0;
         ea_reg <= 1'b0;
         aw_reg <= 1'b0;
         fw_reg <= 1'b0;
         auxm_reg <= 32'h0000_0000;
         l2m_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         ns_reg <= ns_next;
         bank_reg <= bank_next;
         fb_reg <= fb_next;
         irq_reg <= irq_next;
         fiq_reg <= fiq_next;
         ea_reg <= ea_next;
         aw_reg <= aw_next;
         fw_reg <= fw_next;
         auxm_reg <= auxm_next;
         l2m_reg <= l2m_next;
      end
   end

   ////////////////////////////////////////////////////////////
   always_comb begin
      rdata = rdata_reg;
      rd_valid = rdv_reg;
      undef_exc = und_reg;
      nonsec_world = ns_reg;
      bank_nonsec = bank_reg;
      fetch_block = fb_reg;
      irq_to_mon = irq_reg;
      fiq_to_mon = fiq_reg;
      ea_to_mon = ea_reg;
      abt_wr_ok = aw_reg;
      fiq_wr_ok = fw_reg;
      aux_wr_mask = auxm_reg;
      l2_wr_mask = l2m_reg;
   end
endmodule

// [verification/scr_core.sv]
// Core pipeline model issuing coprocessor transfers
`timescale 1ns/1ps
module scr_core (
   input wire logic ref_clk, // Clock
   output logic req, // Valid
   output logic is_rd, // Read
   output logic [3:0] cp, // Coproc
   output logic [2:0] op1, // Op1
   output logic [3:0] crn, // CRn
   output logic [3:0] crm, // CRm
   output logic [2:0] op2, // Op2
   output logic [31:0] wdata // Data
);
   initial {req, is_rd, cp, op1, crn, crm, op2, wdata} = '0;
   // One-cycle transfer; returns at the negedge where the answer is settled
   task automatic xfer(input logic rd, input logic [2:0] o2, input logic [31:0] d);
      @(negedge ref_clk);
      {req, is_rd, cp, op1, crn, crm, op2, wdata} = {1'b1, rd, 15'h7811, o2, d};
      @(negedge ref_clk);
      req = 1'b0;
      wdata = ~d; // Stale data never looks valid
   endtask
endmodule

// [verification/scr_chk.sv]
// Concurrent checks on the security register bank ports
`timescale 1ns/1ps
module scr_chk
   import scr_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic rst, // Reset
   input wire logic clk_en, // Clock enable
   input wire logic req, // Valid
   input wire logic is_rd, // Read
   input wire logic [3:0] cp, // Coproc
   input wire logic [2:0] op1, // Op1
   input wire logic [3:0] crn, // CRn
   input wire logic [3:0] crm, // CRm
   input wire logic [2:0] op2, // Op2
   input wire logic [31:0] wdata, // Data
   input wire logic [4:0] mode, // Mode
   input wire logic abt_wr, // Abort mask req
   input wire logic aux_wr, // Aux write
   input wire logic rd_valid, // Read valid
   input wire logic undef_exc, // Undefined
   input wire logic nonsec_world, // World
   input wire logic bank_nonsec, // Bank
   input wire logic irq_to_mon, // Irq route
   input wire logic fiq_to_mon, // Fiq route
   input wire logic ea_to_mon, // Abort route
   input wire logic abt_wr_ok, // Abort ok
   input wire logic [31:0] aux_wr_mask // Aux mask
);
   default clocking @(posedge ref_clk); endclocking
   // Frozen cycles take no request and move no state
   default disable iff (rst || !clk_en);
   logic c15;
   logic sk;
   assign c15 = req && cp == CP_NUM && op1 == CFG_OP1 && crn == CFG_CRN && crm == CFG_CRM;
   // Secure kernel privilege, as seen by the registered world
   // Registered world lags a cycle: no access may follow a world change at once
   assign sk = mode != MODE_USR && mode != MODE_HYP && (mode == MODE_MON || !nonsec_world);
   sequence cfg_acc; c15 && op2 == CFG_OP2; endsequence
   sequence prm_acc; c15 && op2 == PRM_OP2; endsequence
   cfg_deny_a: assert property (cfg_acc ##0 !sk |=> undef_exc && !rd_valid)
      else $error("config access not refused");
   cfg_read_a: assert property (cfg_acc ##0 (sk && is_rd) |=> rd_valid && !undef_exc)
      else $error("config read refused");
   cfg_write_a: assert property (cfg_acc ##0 (sk && !is_rd) |->
      ##2 {ea_to_mon, fiq_to_mon, irq_to_mon, bank_nonsec} == $past(wdata[3:0], 2))
      else $error("config write not applied");
   mon_secure_a: assert property ((mode == MODE_MON)[*2] |-> !nonsec_world)
      else $error("monitor mode not secure");
   world_sel_a: assert property ((mode != MODE_MON && $stable(bank_nonsec))[*2] |->
      nonsec_world == bank_nonsec) else $error("world not from select bit");
   prm_wr_a: assert property (prm_acc ##0 (!is_rd && !sk) |=> undef_exc)
      else $error("permit write not refused");
   prm_rd_a: assert property (prm_acc ##0 (is_rd && mode != MODE_USR) |=> rd_valid)
      else $error("permit read refused");
   aux_mask_a: assert property (aux_wr && nonsec_world |=>
      (aux_wr_mask & ~(32'h1 << AUX_COH_BIT)) == '0) else $error("aux mask too wide");
   abt_sec_a: assert property (abt_wr && !nonsec_world |=> abt_wr_ok)
      else $error("secure abort mask change refused");
endmodule

// [verification/tb_security_config_regs.sv]
// Self-checking bench for the security register bank
`timescale 1ns/1ps
module tb_security_config_regs
   import scr_pkg::*;
;
   logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
   logic req, is_rd, hyp_call, mon_call, abt_wr, fiq_wr, aux_wr, l2_wr;
   logic [3:0] cp, crn, crm;
   logic [2:0] op1, op2;
   logic [31:0] wdata, rdata, aux_wr_mask, l2_wr_mask;
   logic [4:0] mode = 5'h13;
   logic rd_valid, undef_exc, nonsec_world, bank_nonsec, fetch_block;
   logic irq_to_mon, fiq_to_mon, ea_to_mon, abt_wr_ok, fiq_wr_ok;
   int mismatches = 0;
   int checked = 0;
   initial forever #50 ref_clk = ~ref_clk;
   initial {hyp_call, mon_call, abt_wr, fiq_wr, aux_wr, l2_wr} = '0;
   scr_core i_core (.ref_clk(ref_clk), .req(req), .is_rd(is_rd), .cp(cp), .op1(op1),
      .crn(crn), .crm(crm), .op2(op2), .wdata(wdata));
   scr_top i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req(req), .is_rd(is_rd),
      .cp(cp), .op1(op1), .crn(crn), .crm(crm), .op2(op2), .wdata(wdata), .mode(mode),
      .hyp_call(hyp_call), .mon_call(mon_call), .abt_wr(abt_wr), .fiq_wr(fiq_wr),
      .aux_wr(aux_wr), .l2_wr(l2_wr), .rdata(rdata), .rd_valid(rd_valid),
      .undef_exc(undef_exc), .nonsec_world(nonsec_world), .bank_nonsec(bank_nonsec),
      .fetch_block(fetch_block), .irq_to_mon(irq_to_mon), .fiq_to_mon(fiq_to_mon),
      .ea_to_mon(ea_to_mon), .abt_wr_ok(abt_wr_ok), .fiq_wr_ok(fiq_wr_ok),
      .aux_wr_mask(aux_wr_mask), .l2_wr_mask(l2_wr_mask));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rw(input logic rd, input logic [2:0] o2, input logic [31:0] d,
      input logic [31:0] r, input logic u);
      i_core.xfer(rd, o2, d);
      chk({rd_valid, undef_exc}, {rd && !u, u});
      if (rd && !u) chk(rdata, r);
   endtask
   // Pulse order: hyp, mon, abort, fiq, aux, l2; answers come one edge later
   task automatic pul(input logic [5:0] s, input logic [2:0] u, input logic [31:0] m);
      @(negedge ref_clk);
      {hyp_call, mon_call, abt_wr, fiq_wr, aux_wr, l2_wr} = s;
      @(negedge ref_clk);
      {hyp_call, mon_call, abt_wr, fiq_wr, aux_wr, l2_wr} = '0;
      chk({undef_exc, abt_wr_ok, fiq_wr_ok}, u);
      if (s[1:0] != 2'h0) chk(s[1] ? aux_wr_mask : l2_wr_mask, m);
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Whole sequence needs under a hundred cycles
   initial begin
      repeat (500) @(posedge ref_clk);
      mismatches++;
      finish_test;
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'b0;
      chk({nonsec_world, bank_nonsec, fetch_block, irq_to_mon, fiq_to_mon, ea_to_mon}, 0);
      rw(1, CFG_OP2, 0, CFG_RESET, 0);
      rw(1, PRM_OP2, 0, PRM_RESET, 0);
      pul(6'h08, 3'h2, 0);
      pul(6'h04, 3'h1, 0);
      // Monitor mode stays secure while the world bit goes up
      mode = MODE_MON;
      rw(0, CFG_OP2, 32'hffff_ffff, 0, 0);
      rw(1, CFG_OP2, 0, CFG_MASK, 0);
      mode = 5'h13;
      @(negedge ref_clk);
      chk({nonsec_world, bank_nonsec, fetch_block, irq_to_mon, fiq_to_mon, ea_to_mon}, 6'h37);
      rw(1, CFG_OP2, 0, 0, 1);
      rw(0, PRM_OP2, 32'hffff_ffff, 0, 1);
      rw(1, PRM_OP2, 0, PRM_RESET, 0);
      pul(6'h20, 3'h0, 0);
      pul(6'h10, 3'h4, 0);
      pul(6'h08, 3'h2, 0);
      pul(6'h04, 3'h1, 0);
      pul(6'h02, 3'h0, 0);
      pul(6'h01, 3'h0, 0);
      mode = MODE_MON;
      @(negedge ref_clk);
      chk({nonsec_world, bank_nonsec, fetch_block}, 3'h3);
      rw(0, PRM_OP2, 32'hffff_ffff, 0, 0);
      rw(1, PRM_OP2, 0, PRM_MASK, 0);
      rw(0, CFG_OP2, 32'h0000_0001, 0, 0);
      mode = 5'h13;
      pul(6'h20, 3'h4, 0);
      pul(6'h10, 3'h0, 0);
      pul(6'h08, 3'h0, 0);
      pul(6'h04, 3'h0, 0);
      pul(6'h02, 3'h0, 32'h1 << AUX_COH_BIT);
      pul(6'h01, 3'h0, 32'h1 << L2_ERR_BIT);
      chk({fetch_block, irq_to_mon, fiq_to_mon, ea_to_mon}, 0);
      mode = MODE_USR;
      rw(1, PRM_OP2, 0, 0, 1);
      // Mid-run reset must clear both registers again
      mode = 5'h13;
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      chk({nonsec_world, bank_nonsec, irq_to_mon, fiq_to_mon, ea_to_mon}, 0);
      rw(1, CFG_OP2, 0, CFG_RESET, 0);
      rw(1, PRM_OP2, 0, PRM_RESET, 0);
      // Let the read pulse drop before freezing, else it would stand
      @(negedge ref_clk);
      clk_en = 1'b0;
      rw(0, CFG_OP2, 32'h0000_0002, 0, 0);
      clk_en = 1'b1;
      rw(1, CFG_OP2, 0, CFG_RESET, 0);
      finish_test;
   end
endmodule
bind scr_top scr_chk i_chk (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req(req),
   .is_rd(is_rd), .cp(cp), .op1(op1), .crn(crn), .crm(crm), .op2(op2), .wdata(wdata),
   .mode(mode), .abt_wr(abt_wr), .aux_wr(aux_wr), .rd_valid(rd_valid), .undef_exc(undef_exc),
   .nonsec_world(nonsec_world), .bank_nonsec(bank_nonsec), .irq_to_mon(irq_to_mon),
   .fiq_to_mon(fiq_to_mon), .ea_to_mon(ea_to_mon), .abt_wr_ok(abt_wr_ok),
   .aux_wr_mask(aux_wr_mask));
